// ===== gpo_logic_params.svh
// Constants for the general-purpose output logic port: sizes, register map and timing
`ifndef GPO_LOGIC_PARAMS_SVH
`define GPO_LOGIC_PARAMS_SVH

// Pin and channel counts
`define GPL_NUM_PINS 23
`define GPL_NUM_BIDIR 21
`define GPL_NUM_OUT 10
`define GPL_NUM_IN 8
`define GPL_NUM_RAIL 10
`define GPL_NUM_STAT 17
`define GPL_NUM_DEP 8
`define GPL_OUT_WORDS 6

// Register byte offsets
`define GPL_OFS_CTRL 12'h000
`define GPL_OFS_PIN_LEVEL 12'h004
`define GPL_OFS_PIN_OE 12'h008
`define GPL_OFS_LOGIC_STATE 12'h00c
`define GPL_OFS_CLR_SRC 12'h010
`define GPL_OFS_IN_BASE 12'h040
`define GPL_OFS_OUT_BASE 12'h100
`define GPL_OUT_STRIDE 12'h020

// Field positions and codes
`define GPL_CTRL_STICKY_CLR 0
`define GPL_CLR_SRC_EN 3
`define GPL_SRC_BUS 2'h0
`define GPL_SRC_LOGIC 2'h1
`define GPL_SRC_RAIL 2'h2
`define GPL_STAT_STICKY 5
`define GPL_STAT_POWER_GOOD 5'h00
`define GPL_RESP_OKAY 2'h0
`define GPL_RESP_SLVERR 2'h2
`define GPL_RESET_WORD 32'h0000_0000

// Timing: delay unit in ns and clock period in ns
`define GPL_CLK_NS 5
`define GPL_DLY_UNIT_NS 100000
`define GPL_TICK_CYCLES (`GPL_DLY_UNIT_NS / `GPL_CLK_NS)

`endif

// ===== gpo_logic_pkg.sv
// Types shared by the general-purpose output logic port
package gpo_logic_pkg;

  // Output channel control word
  typedef struct packed {
    logic [11:0] rsv_hi;
    logic [3:0] rail_idx;
    logic rsv_mid;
    logic [4:0] pin_idx;
    logic sm_mode;
    logic ignore_inputs;
    logic dly_deassert;
    logic dly_assert;
    logic open_drain;
    logic active_low;
    logic bus_value;
    logic [1:0] src;
    logic en;
  } out_ctl_t;

  // One AND term: input mask, first-output mask, rail status code
  typedef struct packed {
    logic [9:0] rsv;
    logic [5:0] status;
    logic [7:0] out_mask;
    logic [7:0] in_mask;
  } and_term_t;

  // Input channel configuration word
  typedef struct packed {
    logic [24:0] rsv;
    logic active_low;
    logic [4:0] pin_idx;
    logic en;
  } in_cfg_t;

  // Per-rail live status flags, one bit per status type
  typedef logic [16:0] rail_stat_t;

  // Delay filter states, gray coded
  typedef enum logic [1:0] {
    F_STEADY = 2'b00,
    F_PEND = 2'b01
  } filt_state_t;

endpackage

// ===== gpo_delay_filter.sv
// Assertion/deassertion delay filter for one output logic result
`timescale 1ns/1ps
`default_nettype none
module gpo_delay_filter #(
  parameter int DLY_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic raw,
  input wire logic [DLY_W-1:0] dly_units,
  input wire logic dly_assert,
  input wire logic dly_deassert,
  input wire logic ignore_inputs,
  output logic q
);
  import gpo_logic_pkg::*;

  typedef struct packed {
    filt_state_t st;
    logic target;
    logic [DLY_W-1:0] cnt;
    logic q;
  } filt_t;

  filt_t r_reg, r_next;
  logic need;
  logic expire;

  if (DLY_W < 1 || DLY_W > 31) begin : g_chk
    $error("gpo_delay_filter: DLY_W out of range");
  end

  // Delay applies only in the direction the output is heading
  assign need = (r_reg.st == F_PEND ? r_reg.target : raw) ? dly_assert : dly_deassert;
  assign expire = tick && (r_reg.cnt + DLY_W'(1) >= dly_units);

  always_comb begin
    r_next = r_reg;
    case (r_reg.st)
      F_STEADY: begin
        if (raw != r_reg.q) begin
          if (!need || dly_units == '0) begin
            r_next.q = raw;
          end else begin
            r_next.st = F_PEND;
            r_next.target = raw;
            r_next.cnt = '0;
          end
        end
      end
      F_PEND: begin
        // Normal mode drops a change that reverts in time; ignore mode commits to it
        if (!ignore_inputs && raw == r_reg.q) begin
          r_next.st = F_STEADY;
        end else if (expire) begin
          r_next.q = r_reg.target;
          r_next.st = F_STEADY;
        end else if (tick) begin
          r_next.cnt = r_reg.cnt + DLY_W'(1);
        end
      end
      default: r_next.st = F_STEADY;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_pend_cycle;
    r_reg.st == F_PEND;
  endsequence

  AST_NO_DELAY_PASS: assert property ((r_reg.st == F_STEADY && raw != r_reg.q && !need) |=>
    r_reg.q == $past(raw)) else $error("undelayed change did not pass");
  AST_GLITCH_HELD: assert property ((s_pend_cycle ##0 (!ignore_inputs && raw == r_reg.q)) |=>
    (r_reg.st == F_STEADY && $stable(r_reg.q))) else $error("glitch reached output");
  AST_COMMIT_HELD: assert property ((s_pend_cycle ##0 ignore_inputs ##1 s_pend_cycle) |->
    $stable(r_reg.q)) else $error("output moved during committed delay");
  AST_CHANGE_AT_EXPIRY: assert property (($changed(r_reg.q) && $past(r_reg.st) == F_PEND) |->
    $past(expire) && r_reg.q == $past(r_reg.target)) else $error("early output change");
endmodule
`default_nettype wire

// ===== gpo_boolean_logic_port.sv
// General-purpose pin port with Boolean output logic, delays and AXI4-Lite registers
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_logic_params.svh"
module gpo_boolean_logic_port #(
  parameter int NUM_OUT = `GPL_NUM_OUT,
  parameter int NUM_IN = `GPL_NUM_IN,
  parameter int TICK_CYCLES = `GPL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`GPL_NUM_PINS-1:0] pin_in,
  output logic [`GPL_NUM_PINS-1:0] pin_out,
  output logic [`GPL_NUM_PINS-1:0] pin_oe,
  input wire gpo_logic_pkg::rail_stat_t [`GPL_NUM_RAIL-1:0] rail_status,
  input wire logic [`GPL_NUM_RAIL-1:0] rail_monitored,
  input wire logic [`GPL_NUM_RAIL-1:0] rail_enable_req,
  output logic [`GPL_NUM_DEP-1:0] logic_dep
);
  import gpo_logic_pkg::*;

  localparam int NP = `GPL_NUM_PINS;
  localparam int NR = `GPL_NUM_RAIL;
  localparam int NS = `GPL_NUM_STAT;
  localparam int OW = `GPL_OUT_WORDS;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // Limits of the pin mux and the dependency/term masks
  if (NUM_OUT < `GPL_NUM_DEP || NUM_OUT > `GPL_NUM_OUT || NUM_IN < 1 || NUM_IN > `GPL_NUM_IN ||
      TICK_CYCLES < 1) begin : g_chk
    $error("gpo_boolean_logic_port: parameter out of range");
  end

  // State of the block outside the delay filters
  typedef struct packed {
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [TW-1:0] tick_cnt;
    logic [NUM_IN-1:0][31:0] in_word;
    logic [NUM_OUT-1:0][OW-1:0][31:0] out_word;
    logic [31:0] clr_src;
    logic [NR-1:0][NS-1:0] sticky;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awrdy;
    logic wrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NP-1:0] pout;
    logic [NP-1:0] poe;
    logic [`GPL_NUM_DEP-1:0] dep;
  } state_t;

  state_t r_reg, r_next;
  logic tick;
  logic [NUM_IN-1:0] in_act;
  logic [NUM_OUT-1:0] logic_q;
  logic [NUM_OUT-1:0] raw;
  logic [NUM_OUT-1:0][1:0] term_hit;
  logic sticky_clr;
  logic bus_clr;
  out_ctl_t top_ctl, sm_ctl;

  // Register read mux; unmapped addresses answer SLVERR with zero data
  function automatic logic [32:0] read_word(input state_t s, input logic [11:0] a,
                                            input logic [NUM_OUT-1:0] lq);
    logic [32:0] res;
    res = {1'b1, 32'h0};
    if (a == `GPL_OFS_CTRL) begin
      res = {1'b0, 32'h0};
    end else if (a == `GPL_OFS_PIN_LEVEL) begin
      res = {1'b0, 32'(s.sync2)};
    end else if (a == `GPL_OFS_PIN_OE) begin
      res = {1'b0, 32'(s.poe)};
    end else if (a == `GPL_OFS_LOGIC_STATE) begin
      res = {1'b0, 32'(lq)};
    end else if (a == `GPL_OFS_CLR_SRC) begin
      res = {1'b0, s.clr_src};
    end
    for (int i = 0; i < NUM_IN; i++) begin
      if (a == `GPL_OFS_IN_BASE + 12'(4 * i)) begin
        res = {1'b0, s.in_word[i]};
      end
    end
    for (int j = 0; j < NUM_OUT; j++) begin
      for (int k = 0; k < OW; k++) begin
        if (a == `GPL_OFS_OUT_BASE + 12'(j) * `GPL_OUT_STRIDE + 12'(4 * k)) begin
          res = {1'b0, s.out_word[j][k]};
        end
      end
    end
    return res;
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = d[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign tick = (r_reg.tick_cnt == TW'(TICK_CYCLES - 1));

  // Input channels: select a synced pin and apply its polarity
  always_comb begin
    in_cfg_t c;
    c = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      c = in_cfg_t'(r_reg.in_word[i]);
      in_act[i] = c.en && (int'(c.pin_idx) < NP) && (r_reg.sync2[c.pin_idx] ^ c.active_low);
    end
  end

  // Sticky clear from the bus or from the configured input channel
  assign bus_clr = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid &&
                   r_reg.awaddr == `GPL_OFS_CTRL && r_reg.wstrb[0] &&
                   r_reg.wdata[`GPL_CTRL_STICKY_CLR];
  assign sticky_clr = bus_clr || (r_reg.clr_src[`GPL_CLR_SRC_EN] &&
                      in_act[r_reg.clr_src[2:0]]);

  // Boolean evaluation of every output
  always_comb begin
    out_ctl_t ctl;
    and_term_t t;
    logic [NR-1:0] rmask;
    logic [NR-1:0] rsel;
    logic [4:0] ty;
    ctl = '0;
    t = '0;
    rmask = '0;
    rsel = '0;
    ty = '0;
    for (int j = 0; j < NUM_OUT; j++) begin
      ctl = out_ctl_t'(r_reg.out_word[j][0]);
      for (int p = 0; p < 2; p++) begin
        t = and_term_t'(r_reg.out_word[j][2 + 2 * p]);
        ty = t.status[4:0];
        rmask = r_reg.out_word[j][3 + 2 * p][NR-1:0];
        // Unmonitored rails have no measured power good, so they drop out of the term
        if (ty == `GPL_STAT_POWER_GOOD) begin
          rmask = rmask & rail_monitored;
        end
        for (int k = 0; k < NR; k++) begin
          rsel[k] = (int'(ty) < NS) && (t.status[`GPL_STAT_STICKY] ? r_reg.sticky[k][ty] :
                    rail_status[k][ty]);
        end
        // Empty term is FALSE; otherwise every selected item must be true
        term_hit[j][p] = ((t.in_mask[NUM_IN-1:0] != '0) || (t.out_mask != '0) ||
                          (rmask != '0)) &&
                         ((t.in_mask[NUM_IN-1:0] & ~in_act) == '0) &&
                         ((t.out_mask & ~logic_q[`GPL_NUM_DEP-1:0]) == '0) &&
                         ((rmask & ~rsel) == '0);
      end
      if (ctl.sm_mode) begin
        raw[j] = logic_q[j] ? term_hit[j][0] : term_hit[j][1];
      end else begin
        raw[j] = term_hit[j][0] || term_hit[j][1];
      end
    end
  end

  // One delay filter per output logic channel
  for (genvar j = 0; j < NUM_OUT; j++) begin : g_out
    out_ctl_t cj;
    assign cj = out_ctl_t'(r_reg.out_word[j][0]);
    gpo_delay_filter #(
      .DLY_W(16)
    ) u_filt (
      .clk(clk),
      .rst(rst),
      .tick(tick),
      .raw(raw[j]),
      .dly_units(r_reg.out_word[j][1][15:0]),
      .dly_assert(cj.dly_assert),
      .dly_deassert(cj.dly_deassert),
      .ignore_inputs(cj.ignore_inputs),
      .q(logic_q[j])
    );
  end

  // Next state: synchronisers, prescaler, statuses, bus slave and pin drivers
  always_comb begin
    out_ctl_t ctl;
    logic tv;
    logic lvl;
    logic [32:0] rd;
    ctl = '0;
    tv = 1'b0;
    lvl = 1'b0;
    rd = '0;
    r_next = r_reg;
    r_next.sync1 = pin_in;
    r_next.sync2 = r_reg.sync1;
    r_next.tick_cnt = tick ? '0 : r_reg.tick_cnt + TW'(1);
    // Set wins over clear so an event in the clear cycle is kept
    for (int k = 0; k < NR; k++) begin
      r_next.sticky[k] = (sticky_clr ? '0 : r_reg.sticky[k]) | rail_status[k];
    end
    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && r_reg.awrdy) begin
      r_next.aw_got = 1'b1;
      r_next.awaddr = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && r_reg.wrdy) begin
      r_next.w_got = 1'b1;
      r_next.wdata = s_axi_wdata;
      r_next.wstrb = s_axi_wstrb;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      rd = read_word(r_reg, r_reg.awaddr, logic_q);
      r_next.bresp = rd[32] ? `GPL_RESP_SLVERR : `GPL_RESP_OKAY;
      r_next.bvalid = 1'b1;
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      if (r_reg.awaddr == `GPL_OFS_CLR_SRC) begin
        r_next.clr_src = merge(r_reg.clr_src, r_reg.wdata, r_reg.wstrb);
      end
      for (int i = 0; i < NUM_IN; i++) begin
        if (r_reg.awaddr == `GPL_OFS_IN_BASE + 12'(4 * i)) begin
          r_next.in_word[i] = merge(r_reg.in_word[i], r_reg.wdata, r_reg.wstrb);
        end
      end
      for (int j = 0; j < NUM_OUT; j++) begin
        for (int k = 0; k < OW; k++) begin
          if (r_reg.awaddr == `GPL_OFS_OUT_BASE + 12'(j) * `GPL_OUT_STRIDE + 12'(4 * k)) begin
            r_next.out_word[j][k] = merge(r_reg.out_word[j][k], r_reg.wdata, r_reg.wstrb);
          end
        end
      end
    end else if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    r_next.awrdy = !r_next.aw_got && !r_next.bvalid;
    r_next.wrdy = !r_next.w_got && !r_next.bvalid;
    // Read channel answers one cycle after the address is taken
    if (s_axi_arvalid && r_reg.arrdy) begin
      rd = read_word(r_reg, {s_axi_araddr[11:2], 2'b00}, logic_q);
      r_next.rdata = rd[31:0];
      r_next.rresp = rd[32] ? `GPL_RESP_SLVERR : `GPL_RESP_OKAY;
      r_next.rvalid = 1'b1;
    end else if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    r_next.arrdy = !r_next.rvalid;
    // Pin drivers; a later channel on the same pin takes priority
    r_next.pout = '0;
    r_next.poe = '0;
    for (int j = 0; j < NUM_OUT; j++) begin
      ctl = out_ctl_t'(r_reg.out_word[j][0]);
      if (ctl.src == `GPL_SRC_BUS) begin
        tv = ctl.bus_value;
      end else if (ctl.src == `GPL_SRC_LOGIC) begin
        tv = logic_q[j];
      end else begin
        tv = (int'(ctl.rail_idx) < NR) && rail_enable_req[ctl.rail_idx];
      end
      lvl = tv ^ ctl.active_low;
      // Only the two-way pins can be driven; the last two are input-only
      if (ctl.en && int'(ctl.pin_idx) < `GPL_NUM_BIDIR) begin
        r_next.pout[ctl.pin_idx] = ctl.open_drain ? 1'b0 : lvl;
        r_next.poe[ctl.pin_idx] = ctl.open_drain ? !lvl : 1'b1;
      end
    end
    r_next.dep = logic_q[`GPL_NUM_DEP-1:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = r_reg.awrdy;
  assign s_axi_wready = r_reg.wrdy;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_arready = r_reg.arrdy;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;
  assign pin_out = r_reg.pout;
  assign pin_oe = r_reg.poe;
  assign logic_dep = r_reg.dep;
  // Highest channel always wins its pin, so its drive can be checked without arbitration
  assign top_ctl = out_ctl_t'(r_reg.out_word[NUM_OUT-1][0]);
  assign sm_ctl = out_ctl_t'(r_reg.out_word[1][0]);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write_pair;
    r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
  endsequence

  AST_INPUT_ONLY_PINS: assert property (pin_oe[NP-1:`GPL_NUM_BIDIR] == '0)
    else $error("input-only pin driven");
  AST_OPEN_DRAIN_LOW: assert property ((top_ctl.en && top_ctl.open_drain &&
    int'(top_ctl.pin_idx) < `GPL_NUM_BIDIR) |=> !pin_out[$past(top_ctl.pin_idx)])
    else $error("open-drain pin driven high");
  AST_STICKY_HOLD: assert property (((r_reg.sticky & ~r_next.sticky) != '0) |-> sticky_clr)
    else $error("sticky status dropped without clear");
  AST_STICKY_SET: assert property ((rail_status != '0) |=>
    ((r_reg.sticky & $past(rail_status)) == $past(rail_status)))
    else $error("status event lost");
  AST_DEP_STATE: assert property (##1 logic_dep == $past(logic_q[`GPL_NUM_DEP-1:0]))
    else $error("dependency output stale");
  AST_SM_PATH: assert property ((sm_ctl.sm_mode && logic_q[1] &&
    !term_hit[1][0]) |-> !raw[1]) else $error("state machine path wrong");
  AST_WRITE_RESP: assert property (s_write_pair |=> s_axi_bvalid ##0 !r_reg.aw_got)
    else $error("write response missing");
endmodule
`default_nettype wire

// ===== gpo_far_side.sv
// Far-side model: board pull-ups and external drivers on the port's pins
`timescale 1ns/1ps
`default_nettype none
`include "gpo_logic_params.svh"
module gpo_far_side (
  input wire logic [`GPL_NUM_PINS-1:0] pin_out,
  input wire logic [`GPL_NUM_PINS-1:0] pin_oe,
  input wire logic [`GPL_NUM_PINS-1:0] ext_en,
  input wire logic [`GPL_NUM_PINS-1:0] ext_val,
  output logic [`GPL_NUM_PINS-1:0] pin_line
);
  // Device drive wins; otherwise an external source; otherwise the pull-up
  // The pull-up is what turns a released open-drain pin into a high level
  always_comb begin
    for (int i = 0; i < `GPL_NUM_PINS; i++) begin
      pin_line[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

// ===== tb_gpo_boolean_logic_port.sv
// Self-checking bench for the general-purpose output logic port
`timescale 1ns/1ps
`default_nettype none
`include "gpo_logic_params.svh"
module tb_gpo_boolean_logic_port;
  import gpo_logic_pkg::*;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [22:0] pin_in, pin_out, pin_oe, ext_en, ext_val;
  rail_stat_t [9:0] rail_status;
  logic [9:0] rail_monitored, rail_enable_req;
  logic [7:0] logic_dep;
  int n_errors, comparisons, seed;

  // Short delay unit keeps the delay scenarios within a few dozen cycles
  gpo_boolean_logic_port #(.TICK_CYCLES(4)) dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
    .rail_status, .rail_monitored, .rail_enable_req, .logic_dep);
  gpo_far_side far (.pin_out, .pin_oe, .ext_en, .ext_val, .pin_line(pin_in));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic tmo(input string m);
    n_errors++;
    $display("BAD %0t no answer on %s", $time, m);
    conclude();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) tmo("write");
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 50) tmo("read");
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Counts cycles until a pin line reaches a level, giving up at lim
  task automatic waitln(input int p, input logic v, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      if (pin_in[p] === v) break;
      @(posedge clk);
    end
  endtask

  // Output control word: f = {sm, ignore, dly deassert, dly assert, open drain, low, value}
  function automatic logic [31:0] ctl(input logic [4:0] p, input logic [1:0] s,
                                      input logic [6:0] f, input logic [3:0] rl);
    return {12'h0, rl, 1'b0, p, f, s, 1'b1};
  endfunction

  function automatic logic [11:0] oa(input int j, input int w);
    return 12'(32'h100 + 32'h20 * j + 4 * w);
  endfunction

  // Pin level expected from a logic result and the output polarity
  function automatic logic lvl(input logic res, input logic low);
    return res ^ low;
  endfunction

  initial begin
    int i, p, t, s, n;
    logic e;
    logic [11:0] ma [4];
    seed = 32'h0abf4de6;
    ma = '{12'h234, 12'h240, 12'h05c, 12'h060};
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    ext_en = 23'h000043;
    ext_val = 23'h0;
    rail_status = '0;
    rail_monitored = 10'h3ff;
    rail_enable_req = 10'h0;
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    // Reset state and the edges of the channel map
    rd(`GPL_OFS_PIN_OE, d);
    chk(d, 32'h0, "drive after reset");
    for (i = 0; i < 4; i++) begin
      rd(ma[i], d);
      chk(r, (i % 2) ? `GPL_RESP_SLVERR : `GPL_RESP_OKAY, "channel count");
    end
    wr(12'h030, 32'h1);
    chk(r, `GPL_RESP_SLVERR, "unmapped write");
    $display("map test done");
    // Bus-driven output over every value, polarity and drive mode, random pin
    for (i = 0; i < 8; i++) begin
      p = 10 + $unsigned($random(seed)) % 11;
      wr(oa(9, 0), ctl(p[4:0], `GPL_SRC_BUS, {4'h0, i[2:0]}, 4'h0));
      cyc(3);
      chk(pin_in[p], lvl(i[0], i[1]), "bus level");
      chk(pin_oe[p], !(i[2] && lvl(i[0], i[1])), "drive mode");
      wr(oa(9, 0), 32'h0);
      cyc(3);
      chk(pin_oe[p], 1'b0, "released");
    end
    wr(oa(9, 0), ctl(5'd21, `GPL_SRC_BUS, 7'h1, 4'h0));
    cyc(3);
    chk(pin_oe[22:21], 2'h0, "input-only pins");
    $display("bus output test done");
    // Logic outputs: out1 = in0 | in1 (in1 active low), out3 follows out1
    wr(12'h040, 32'h1);
    wr(12'h044, 32'h43);
    wr(oa(1, 0), ctl(5'd2, `GPL_SRC_LOGIC, 7'h2, 4'h0));
    wr(oa(1, 2), 32'h1);
    wr(oa(1, 4), 32'h2);
    wr(oa(3, 0), ctl(5'd4, `GPL_SRC_LOGIC, 7'h0, 4'h0));
    wr(oa(3, 2), 32'h200);
    for (i = 0; i < 4; i++) begin
      ext_val[1:0] <= i[1:0];
      cyc(14);
      e = i[0] | !i[1];
      chk(pin_in[2], lvl(e, 1'b1), "or of terms");
      chk(logic_dep[1], e, "dependency state");
      chk(pin_in[4], e, "output as input");
    end
    $display("logic test done");
    // Rail-enable source follows the sequencer request
    wr(oa(2, 0), ctl(5'd3, `GPL_SRC_RAIL, 7'h0, 4'd3));
    for (i = 1; i >= 0; i--) begin
      rail_enable_req[3] <= i[0];
      cyc(6);
      chk(pin_in[3], i[0], "rail enable");
    end
    $display("rail enable test done");
    // Every status type, plain and sticky; sticky cleared by command or input pin
    wr(12'h048, 32'hd);
    wr(`GPL_OFS_CLR_SRC, 32'ha);
    wr(oa(4, 0), ctl(5'd5, `GPL_SRC_LOGIC, 7'h0, 4'h0));
    wr(oa(4, 3), 32'h1);
    for (i = 0; i < 34; i++) begin
      t = i % 17;
      s = i / 17;
      if (i == 17) wr(`GPL_OFS_CTRL, 32'h1);
      wr(oa(4, 2), {10'h0, s[0], t[4:0], 16'h0});
      rail_status[0] <= 17'h1 << t;
      cyc(8);
      chk(pin_in[5], 1'b1, "status set");
      rail_status[0] <= 17'h0;
      cyc(8);
      chk(pin_in[5], s[0], "status hold");
      if (s[0] && !t[0]) wr(`GPL_OFS_CTRL, 32'h1);
      else if (s[0]) begin
        ext_val[6] <= 1'b1;
        cyc(3);
        ext_val[6] <= 1'b0;
      end
      cyc(8);
      chk(pin_in[5], 1'b0, "status cleared");
    end
    // Power good of an unmonitored rail takes no part
    wr(oa(4, 2), 32'h0);
    wr(oa(4, 3), 32'h3);
    rail_monitored <= 10'h3fd;
    rail_status[0] <= 17'h1;
    cyc(8);
    chk(pin_in[5], 1'b1, "unmonitored rail");
    rail_monitored <= 10'h3ff;
    cyc(8);
    chk(pin_in[5], 1'b0, "monitored rail");
    $display("status test done");
    // Delays of 3 units: a short pulse is filtered, or stretched when ignoring
    wr(oa(1, 4), 32'h0);
    wr(oa(1, 1), 32'h3);
    for (i = 0; i < 2; i++) begin
      ext_val[1:0] <= 2'h0;
      wr(oa(1, 0), ctl(5'd2, `GPL_SRC_LOGIC, {1'b0, i[0], 5'b11000}, 4'h0));
      cyc(30);
      ext_val[0] <= 1'b1;
      cyc(3);
      ext_val[0] <= 1'b0;
      waitln(2, 1'b1, 30, n);
      chk(n < 30, i[0], "short pulse");
      if (i == 1) begin
        waitln(2, 1'b0, 30, n);
        chk(n >= 8, 1'b1, "pulse width");
      end
      cyc(20);
      ext_val[0] <= 1'b1;
      waitln(2, 1'b1, 40, n);
      chk(n >= 8 && n < 40, 1'b1, "assert delay");
      ext_val[0] <= 1'b0;
      waitln(2, 1'b0, 40, n);
      chk(n >= 8 && n < 40, 1'b1, "deassert delay");
    end
    $display("delay test done");
    // State machine: path 1 sets (in1 low), path 0 holds while in0 stays high
    wr(oa(1, 1), 32'h0);
    wr(oa(1, 0), ctl(5'd2, `GPL_SRC_LOGIC, 7'h40, 4'h0));
    wr(oa(1, 4), 32'h2);
    for (i = 0; i < 5; i++) begin
      ext_val[1:0] <= {((5'b00100 >> i) & 5'h1) == 5'h0, ((5'b01110 >> i) & 5'h1) != 5'h0};
      cyc(14);
      chk(pin_in[2], 5'b01100 >> i & 1'b1, "two-path state");
    end
    $display("state machine test done");
    conclude();
  end

  // Last resort against a hang anywhere in the sequence
  initial begin
    #400000;
    tmo("run");
  end
endmodule
`default_nettype wire
